//--- core/sfr_pkg.sv
// shared constants and types of the spi flag and status readout
package sfr_pkg;

    // serial command word layout
    localparam int SFR_CMD_W = 16;
    localparam int SFR_CMD_MSB = 15;
    localparam int SFR_MODE_HI = 15;
    localparam int SFR_MODE_LO = 14;
    localparam int SFR_ADDR_HI = 13;
    localparam int SFR_ADDR_LO = 9;
    localparam int SFR_SEL_BIT = 7;
    localparam int SFR_BYTE_W = 8;

    // link bit counter: byte select edge and full word
    localparam logic [4:0] SFR_CNT_SEL = 5'h08;
    localparam logic [4:0] SFR_CNT_FULL = 5'h10;
    localparam logic [4:0] SFR_CNT_ONE = 5'h01;

    // access modes in the two top command bits
    localparam logic [1:0] SFR_MODE_FLAG = 2'h3;
    localparam logic [1:0] SFR_MODE_LIVE = 2'h0;

    // group addresses in command bits 13..9
    localparam logic [4:0] SFR_ADDR_SUPPLY = 5'h0f;
    localparam logic [4:0] SFR_ADDR_XCVR = 5'h10;
    localparam logic [4:0] SFR_ADDR_MISC = 5'h11;

    // flag group indices; each address owns two, bit 7 picks one
    localparam int SFR_N_GRP = 6;
    localparam logic [2:0] SFR_GRP_SUPPLY = 3'h0;
    localparam logic [2:0] SFR_GRP_XCVR = 3'h2;
    localparam logic [2:0] SFR_GRP_MISC = 3'h4;
    localparam logic [2:0] SFR_LIVE_IDX = 3'h6;

    // implemented flag bits per group, index 5 first; others read zero
    localparam logic [SFR_N_GRP-1:0][7:0] SFR_FLAG_MASK = {
        8'hff, 8'hff, 8'hff, 8'hbf, 8'h17, 8'hff
    };
    localparam logic [4:0] SFR_LIVE_PAD = 5'h00;

    typedef logic [SFR_BYTE_W-1:0] sfr_byte_t;

    // live failure conditions from the detectors, one byte per group
    typedef struct packed {
        sfr_byte_t wake_src;
        sfr_byte_t misc;
        sfr_byte_t bus_short;
        sfr_byte_t xcvr;
        sfr_byte_t supply_hi;
        sfr_byte_t supply_lo;
    } sfr_cond_s;

    // present transceiver state, returned in bits 7..5
    typedef struct packed {
        logic drv_on;
        logic rcv_on;
        logic wake_en;
    } sfr_live_s;

    typedef enum logic [2:0] {
        SFR_ST_IDLE = 3'h1,
        SFR_ST_FRAME = 3'h2,
        SFR_ST_CLEAR = 3'h4
    } sfr_state_e;

endpackage

//--- core/sfr_flag_latch.sv
// one byte of latched failure flags with read-clear
`timescale 1ns/1ps
module sfr_flag_latch (
    input wire logic clk,
    input wire logic rst,
    input wire sfr_pkg::sfr_byte_t cond,
    input wire logic clr,
    output sfr_pkg::sfr_byte_t flags
);

    sfr_pkg::sfr_byte_t flags_r;
    sfr_pkg::sfr_byte_t flags_nxt;
    sfr_pkg::sfr_byte_t clr_mask;

    // clear only bits whose cause is gone; a live cause sets again, set wins
    assign clr_mask = clr ? ~cond : '0;
    assign flags_nxt = (flags_r & ~clr_mask) | cond;
    assign flags = flags_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags_r <= '0;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    property p_set;
        @(posedge clk) disable iff (rst)
        (cond != '0) |=> ((flags_r & $past(cond)) == $past(cond));
    endproperty
    a_set: assert property (p_set) else $error("raised condition not latched");

    property p_hold;
        @(posedge clk) disable iff (rst)
        !clr |=> ((flags_r & $past(flags_r)) == $past(flags_r));
    endproperty
    a_hold: assert property (p_hold) else $error("flag lost without read");

    property p_clear;
        @(posedge clk) disable iff (rst)
        (clr && cond == '0) |=> (flags_r == '0);
    endproperty
    a_clear: assert property (p_clear) else $error("read did not clear flags");

endmodule

//--- core/sfr_readout.sv
// spi flag and status readout: command capture, flag latches, byte return
`timescale 1ns/1ps
module sfr_readout (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire sfr_pkg::sfr_cond_s fault_cond,
    input wire sfr_pkg::sfr_live_s live_state,
    input wire logic sclk_link,
    input wire logic serial_select_low,
    input wire logic mosi,
    output logic miso_o,
    output logic miso_oe
);

    // group lookup: {hit, index}; bit 7 of the command picks the byte
    function automatic logic [3:0] grp_of(input logic [4:0] addr,
                                          input logic sel);
        logic [2:0] base;
        logic hit;
        base = '0;
        hit = 1'b1;
        case (addr)
            sfr_pkg::SFR_ADDR_SUPPLY: base = sfr_pkg::SFR_GRP_SUPPLY;
            sfr_pkg::SFR_ADDR_XCVR: base = sfr_pkg::SFR_GRP_XCVR;
            sfr_pkg::SFR_ADDR_MISC: base = sfr_pkg::SFR_GRP_MISC;
            default: hit = 1'b0;
        endcase
        grp_of = {hit, base + {2'b00, sel}};
    endfunction

    // ------------------------------------------------------------------
    // link side, clocked by the host's serial clock
    // ------------------------------------------------------------------

    logic rst_link;
    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    logic [3:0] bit_idx;
    logic [sfr_pkg::SFR_CMD_W-1:0] cmd_r;
    logic seq_r;
    logic miso_r;
    logic [6:0] tx_r;
    logic cnt_open;
    logic at_sel;

    // counter restarts whenever the select pin is released
    assign rst_link = sys_rst | serial_select_low;
    assign cnt_open = (cnt_r != sfr_pkg::SFR_CNT_FULL);
    assign cnt_nxt = cnt_open ? cnt_r + sfr_pkg::SFR_CNT_ONE : cnt_r;
    assign bit_idx = 4'(sfr_pkg::SFR_CMD_MSB) - cnt_r[3:0];
    assign at_sel = (cnt_r == sfr_pkg::SFR_CNT_SEL);

    always_ff @(posedge sclk_link or posedge rst_link) begin
        if (rst_link) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // command word kept after the frame so the core side can read it;
    // bits past the sixteenth are ignored
    always_ff @(posedge sclk_link or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_r <= '0;
        end else if (cnt_open) begin
            cmd_r[bit_idx] <= mosi;
        end
    end

    // toggles once per complete word; an empty select pulse clears nothing
    always_ff @(posedge sclk_link or posedge sys_rst) begin
        if (sys_rst) begin
            seq_r <= 1'b0;
        end else if (cnt_nxt == sfr_pkg::SFR_CNT_FULL && cnt_open) begin
            seq_r <= ~seq_r;
        end
    end

    // return byte choice, with bit 7 taken live from the pin at its edge
    logic [1:0] hdr_mode;
    logic [4:0] hdr_addr;
    logic [3:0] hdr_grp;
    logic hdr_flag;
    logic hdr_live;
    sfr_pkg::sfr_byte_t ret_byte;
    sfr_pkg::sfr_byte_t snap_r [0:sfr_pkg::SFR_N_GRP];

    assign hdr_mode = cmd_r[sfr_pkg::SFR_MODE_HI:sfr_pkg::SFR_MODE_LO];
    assign hdr_addr = cmd_r[sfr_pkg::SFR_ADDR_HI:sfr_pkg::SFR_ADDR_LO];
    assign hdr_grp = grp_of(hdr_addr, mosi);
    assign hdr_flag = (hdr_mode == sfr_pkg::SFR_MODE_FLAG);
    assign hdr_live = (hdr_mode == sfr_pkg::SFR_MODE_LIVE) &&
                      (hdr_addr == sfr_pkg::SFR_ADDR_XCVR) && mosi;
    // bit 8 is not looked at: no parity applies to reads
    assign ret_byte = (hdr_flag && hdr_grp[3]) ? snap_r[hdr_grp[2:0]] :
                      hdr_live ? snap_r[sfr_pkg::SFR_LIVE_IDX] :
                      '0;

    // output changes on rising edges; zeros in the high byte, then the
    // chosen byte msb first from the ninth edge on
    always_ff @(posedge sclk_link or posedge rst_link) begin
        if (rst_link) begin
            miso_r <= 1'b0;
            tx_r <= '0;
        end else if (at_sel) begin
            {miso_r, tx_r} <= ret_byte;
        end else begin
            {miso_r, tx_r} <= {tx_r, 1'b0};
        end
    end

    assign miso_o = miso_r;
    assign miso_oe = ~serial_select_low;

    // ------------------------------------------------------------------
    // core side, on ref_clk
    // ------------------------------------------------------------------

    logic ssl_meta_r;
    logic ssl_sync_r;
    logic seq_meta_r;
    logic seq_sync_r;
    logic seq_seen_r;
    logic frame_act;
    sfr_pkg::sfr_state_e state_r;
    sfr_pkg::sfr_state_e state_nxt;

    // select level and word toggle, two flops each before use
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ssl_meta_r <= 1'b1;
            ssl_sync_r <= 1'b1;
            seq_meta_r <= 1'b0;
            seq_sync_r <= 1'b0;
        end else begin
            ssl_meta_r <= serial_select_low;
            ssl_sync_r <= ssl_meta_r;
            seq_meta_r <= seq_r;
            seq_sync_r <= seq_meta_r;
        end
    end

    assign frame_act = ~ssl_sync_r;

    // idle -> frame while selected -> one clear cycle after release
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            sfr_pkg::SFR_ST_IDLE: begin
                if (frame_act) begin
                    state_nxt = sfr_pkg::SFR_ST_FRAME;
                end
            end
            sfr_pkg::SFR_ST_FRAME: begin
                if (!frame_act) begin
                    state_nxt = sfr_pkg::SFR_ST_CLEAR;
                end
            end
            sfr_pkg::SFR_ST_CLEAR: begin
                state_nxt = sfr_pkg::SFR_ST_IDLE;
            end
            default: begin
                state_nxt = sfr_pkg::SFR_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= sfr_pkg::SFR_ST_IDLE;
            seq_seen_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (state_r == sfr_pkg::SFR_ST_CLEAR) begin
                seq_seen_r <= seq_sync_r;
            end
        end
    end

    // decode of the finished word; cmd_r has been still since the frame end
    logic in_clear;
    logic new_read;
    logic rd_flag_c;
    logic rd_live_c;
    logic [3:0] grp_c;
    logic [sfr_pkg::SFR_N_GRP-1:0] clr_vec;

    assign in_clear = (state_r == sfr_pkg::SFR_ST_CLEAR);
    assign new_read = in_clear && (seq_sync_r != seq_seen_r);
    assign rd_flag_c = (hdr_mode == sfr_pkg::SFR_MODE_FLAG);
    assign rd_live_c = (hdr_mode == sfr_pkg::SFR_MODE_LIVE);
    assign grp_c = grp_of(hdr_addr, cmd_r[sfr_pkg::SFR_SEL_BIT]);
    assign clr_vec = (new_read && rd_flag_c && grp_c[3]) ?
                     sfr_pkg::SFR_N_GRP'(1) << grp_c[2:0] : '0;

    // flag latches, one per group; unused bit positions never set
    logic [sfr_pkg::SFR_N_GRP-1:0][7:0] cond_a;
    logic [sfr_pkg::SFR_N_GRP-1:0][7:0] cond_m;
    logic [sfr_pkg::SFR_N_GRP-1:0][7:0] flags_a;

    assign cond_a = fault_cond;
    assign cond_m = cond_a & sfr_pkg::SFR_FLAG_MASK;

    genvar g;
    generate
        for (g = 0; g < sfr_pkg::SFR_N_GRP; g++) begin : gen_grp
            sfr_flag_latch u_latch (
                .clk(ref_clk),
                .rst(sys_rst),
                .cond(cond_m[g]),
                .clr(clr_vec[g]),
                .flags(flags_a[g])
            );
        end
    endgenerate

    // snapshot read by the link side; frozen from select sync until after
    // the clear, so it is quasi-static whenever the link samples it.
    // limitation: the host must leave a few ref_clk cycles after select
    // falls before the ninth clock edge
    logic snap_load;
    sfr_pkg::sfr_byte_t live_byte;

    assign snap_load = (state_r == sfr_pkg::SFR_ST_IDLE) && !frame_act;
    assign live_byte = {live_state, sfr_pkg::SFR_LIVE_PAD};

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i <= sfr_pkg::SFR_N_GRP; i++) begin
                snap_r[i] <= '0;
            end
        end else if (snap_load) begin
            for (int i = 0; i < sfr_pkg::SFR_N_GRP; i++) begin
                snap_r[i] <= flags_a[i];
            end
            snap_r[sfr_pkg::SFR_N_GRP] <= live_byte;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------

    property p_rd_clear;
        @(posedge ref_clk) disable iff (sys_rst)
        (new_read && rd_flag_c && grp_c[3] && cond_m[grp_c[2:0]] == '0)
        |=> (flags_a[$past(grp_c[2:0])] == '0);
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("flag read left flags set");

    property p_live_keep;
        @(posedge ref_clk) disable iff (sys_rst)
        (new_read && rd_live_c) |-> (clr_vec == '0);
    endproperty
    a_live_keep: assert property (p_live_keep) else $error("live read cleared flags");

    property p_addr_miss;
        @(posedge ref_clk) disable iff (sys_rst)
        (in_clear && !grp_c[3]) |-> (clr_vec == '0);
    endproperty
    a_addr_miss: assert property (p_addr_miss) else $error("unknown group cleared");

    property p_no_parity;
        @(posedge ref_clk) disable iff (sys_rst)
        (new_read && rd_flag_c && grp_c[3]) |-> $onehot(clr_vec);
    endproperty
    a_no_parity: assert property (p_no_parity) else $error("flag read refused");

    property p_frozen;
        @(posedge ref_clk) disable iff (sys_rst)
        (state_r == sfr_pkg::SFR_ST_FRAME) |=> $stable(snap_r[sfr_pkg::SFR_LIVE_IDX]);
    endproperty
    a_frozen: assert property (p_frozen) else $error("snapshot moved in frame");

    property p_head_zero;
        @(posedge sclk_link) disable iff (rst_link)
        (cnt_r < sfr_pkg::SFR_CNT_SEL) |=> !miso_r;
    endproperty
    a_head_zero: assert property (p_head_zero) else $error("high byte not zero");

    property p_byte_out;
        @(posedge sclk_link) disable iff (rst_link)
        at_sel |=> (miso_r == $past(ret_byte[7])) ##1
        (miso_r == $past(ret_byte[6], 2));
    endproperty
    a_byte_out: assert property (p_byte_out) else $error("byte not shifted out");

    property p_tail;
        @(posedge sclk_link) disable iff (rst_link)
        (cnt_r == sfr_pkg::SFR_CNT_FULL) |=> !miso_r;
    endproperty
    a_tail: assert property (p_tail) else $error("output after word end");

endmodule

//--- tb/sfr_host_model.sv
// host side serial master model that sends command frames and collects the reply
`timescale 1ns/1ps
module sfr_host_model (
    input wire logic ref_clk,
    input wire logic miso,
    output logic sclk_link,
    output logic serial_select_low,
    output logic mosi
);
    // idle pins: clock parked low, select released
    initial begin
        sclk_link = 1'b0;
        serial_select_low = 1'b1;
        mosi = 1'b0;
    end

    // one frame of nedge bits, msb first; the clock only runs inside the frame
    task automatic xfer(input logic [15:0] cmd, input int nedge, output logic [15:0] resp);
        resp = 16'h0000;
        @(negedge ref_clk);
        serial_select_low = 1'b0;
        // lead time well over four core cycles before the first edge
        #213;
        for (int i = 0; i < nedge; i++) begin
            // edges past the word carry a plain zero the device must ignore
            mosi = (i < 16) ? cmd[15 - i] : 1'b0;
            #80 sclk_link = 1'b1;
            #80 sclk_link = 1'b0;
            resp = {resp[14:0], miso};
        end
        #80;
        @(negedge ref_clk);
        serial_select_low = 1'b1;
        // released line must not keep showing the last bit
        mosi = ~mosi;
    endtask
endmodule

//--- tb/spi_flag_status_readout_tb_top.sv
// self-checking bench of the spi flag and status readout
`timescale 1ns/1ps
module spi_flag_status_readout_tb_top;
    logic ref_clk;
    logic sys_rst;
    sfr_pkg::sfr_cond_s fault_cond;
    sfr_pkg::sfr_live_s live_state;
    logic sclk_link;
    logic serial_select_low;
    logic mosi;
    logic miso_o;
    logic miso_oe;
    logic miso_idle;
    wire logic miso_w;
    logic [47:0] cond_v;
    logic [5:0][7:0] exp_flags;
    int n_fail;
    int checks;
    int cycles = 0;

    sfr_readout u_dut (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .fault_cond(fault_cond),
        .live_state(live_state),
        .sclk_link(sclk_link),
        .serial_select_low(serial_select_low),
        .mosi(mosi),
        .miso_o(miso_o),
        .miso_oe(miso_oe)
    );

    sfr_host_model u_host (
        .ref_clk(ref_clk),
        .miso(miso_w),
        .sclk_link(sclk_link),
        .serial_select_low(serial_select_low),
        .mosi(mosi)
    );

    // undriven miso toggles so a stale value can never pass
    assign miso_w = miso_oe ? miso_o : miso_idle;

    always @(posedge ref_clk) begin
        miso_idle <= ~miso_idle;
    end

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // hang guard, far above the few thousand cycles the run needs
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_fail++;
            final_report();
        end
    end

    task automatic final_report();
        if (n_fail == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // byte the device should return; refused modes and addresses give zero
    function automatic logic [7:0] exp_byte(input logic [1:0] mode, input logic [4:0] addr,
                                            input logic sel);
        int g;
        g = 2 * (int'(addr) - 15) + int'(sel);
        if (mode == sfr_pkg::SFR_MODE_FLAG && addr >= 5'h0f && addr <= 5'h11) begin
            return exp_flags[g];
        end
        if (mode == sfr_pkg::SFR_MODE_LIVE && addr == 5'h10 && sel) begin
            return {live_state, 5'h00};
        end
        return 8'h00;
    endfunction

    // hold a condition pattern long enough for the latches to see it
    task automatic set_cond(input logic [47:0] v);
        @(negedge ref_clk);
        cond_v = v;
        fault_cond = sfr_pkg::sfr_cond_s'(v);
        repeat (3) @(negedge ref_clk);
        for (int g = 0; g < 6; g++) begin
            exp_flags[g] = exp_flags[g] | (v[g*8 +: 8] & sfr_pkg::SFR_FLAG_MASK[g]);
        end
    endtask

    // one read frame, then the idle gap the clear and reload need
    task automatic do_read(input logic [1:0] mode, input logic [4:0] addr, input logic sel,
                           input int nedge);
        logic [15:0] resp;
        logic [7:0] e;
        int g;
        logic [15:0] exp_w;
        e = exp_byte(mode, addr, sel);
        g = 2 * (int'(addr) - 15) + int'(sel);
        // the host keeps the last sixteen bits it clocked in
        exp_w = (nedge > 16) ? ({8'h00, e} << (nedge - 16)) : ({8'h00, e} >> (16 - nedge));
        u_host.xfer({mode, addr, 1'b1, sel, 7'h00}, nedge, resp);
        check("miso word", exp_w, resp);
        if (nedge >= 16 && mode == sfr_pkg::SFR_MODE_FLAG && addr >= 5'h0f && addr <= 5'h11) begin
            exp_flags[g] = exp_flags[g] & cond_v[g*8 +: 8];
        end
        repeat (8) @(negedge ref_clk);
    endtask

    initial begin
        sys_rst = 1'b1;
        fault_cond = '0;
        live_state = '0;
        miso_idle = 1'b0;
        cond_v = '0;
        exp_flags = '0;
        n_fail = 0;
        checks = 0;
        void'($urandom(32'hf096_6b5f));
        repeat (3) @(negedge ref_clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge ref_clk);
        check("idle output enable", 16'h0000, {15'h0000, miso_oe});
        // every flag byte clear after reset
        for (int i = 0; i < 6; i++) begin
            do_read(sfr_pkg::SFR_MODE_FLAG, 5'(5'h0f + i / 2), 1'(i % 2), 16);
        end
        // all faults, then some persist past the read
        set_cond(48'hffff_ffff_ffff);
        set_cond(48'h0000_0000_8001);
        do_read(2'h1, 5'h0f, 1'b0, 16);
        do_read(2'h2, 5'h0f, 1'b0, 16);
        do_read(sfr_pkg::SFR_MODE_FLAG, 5'h12, 1'b0, 16);
        do_read(sfr_pkg::SFR_MODE_FLAG, 5'h10, 1'b0, 12);
        // overlong frame: extra edges give zeros and still clear
        do_read(sfr_pkg::SFR_MODE_FLAG, 5'h11, 1'b1, 18);
        for (int i = 0; i < 6; i++) begin
            do_read(sfr_pkg::SFR_MODE_FLAG, 5'(5'h0f + i / 2), 1'(i % 2), 16);
            do_read(sfr_pkg::SFR_MODE_FLAG, 5'(5'h0f + i / 2), 1'(i % 2), 16);
        end
        // every live state combination, plus the unused byte
        for (int i = 0; i < 8; i++) begin
            @(negedge ref_clk);
            live_state = sfr_pkg::sfr_live_s'(3'(i));
            do_read(sfr_pkg::SFR_MODE_LIVE, 5'h10, 1'b1, 16);
        end
        do_read(sfr_pkg::SFR_MODE_LIVE, 5'h10, 1'b0, 16);
        // random faults, partly persisting, read through random commands
        repeat (40) begin
            set_cond({16'($urandom), $urandom} & {16'($urandom), $urandom});
            set_cond(cond_v & {16'($urandom), $urandom});
            @(negedge ref_clk);
            live_state = sfr_pkg::sfr_live_s'(3'($urandom));
            do_read(2'($urandom), 5'(5'h0f + $urandom_range(0, 2)), 1'($urandom), 16);
        end
        // mid-run reset drops every latched flag
        set_cond(48'hffff_ffff_ffff);
        set_cond('0);
        sys_rst = 1'b1;
        repeat (3) @(negedge ref_clk);
        sys_rst = 1'b0;
        exp_flags = '0;
        repeat (4) @(negedge ref_clk);
        do_read(sfr_pkg::SFR_MODE_FLAG, 5'h0f, 1'b0, 16);
        do_read(sfr_pkg::SFR_MODE_FLAG, 5'h11, 1'b1, 16);
        final_report();
    end
endmodule
